// ==== rtl/rgi_regs.vh ====
// Constants for the RGB pixel input and display RAM addressing block.
// Assumes a 20 MHz system clock and plain-port register access.
`ifndef RGI_REGS_VH
`define RGI_REGS_VH
`define RGI_REG_CTRL 4'h0
`define RGI_REG_ORIENT 4'h1
`define RGI_REG_COL_START 4'h2
`define RGI_REG_COL_END 4'h3
`define RGI_REG_PAGE_START 4'h4
`define RGI_REG_PAGE_END 4'h5
`define RGI_REG_CMD 4'h6
`define RGI_REG_STATUS 4'h7
`define RGI_REG_SCROLL_TOP 4'h8
`define RGI_REG_SCROLL_AREA 4'h9
`define RGI_REG_SCROLL_BOT 4'hA
`define RGI_REG_SCROLL_START 4'hB
`define RGI_REG_RDDATA 4'hC
`define RGI_CTRL_NARROW 0
`define RGI_CTRL_MEMPATH 1
`define RGI_CTRL_MODE_LO 2
`define RGI_CTRL_MODE_HI 3
`define RGI_CTRL_FMT_LO 4
`define RGI_CTRL_FMT_HI 6
`define RGI_CTRL_RGB_EN 7
`define RGI_CTRL_CONT 8
`define RGI_ORIENT_EXCH 0
`define RGI_ORIENT_CMIR 1
`define RGI_ORIENT_PMIR 2
`define RGI_CMD_WRITE 8'h2C
`define RGI_CMD_READ 8'h2E
`define RGI_CMD_STOP 8'h00
`define RGI_CMD_VSCRDEF 8'h33
`define RGI_CMD_VSCSAD 8'h37
`define RGI_MODE_DE 2'h2
`define RGI_MODE_SYNC 2'h3
`define RGI_FMT_18 3'h6
`define RGI_FMT_16 3'h5
`define RGI_COLS 240
`define RGI_PAGES 320
`define RGI_COL_LAST 9'h0EF
`define RGI_PAGE_LAST 9'h13F
`define RGI_RAM_WORDS 76800
`define RGI_CTRL_RESET 9'h000
`endif

// ==== rtl/rgi_core.v ====
// RGB video input path, display RAM and its column and page counters.
// Assumes pixel pins, syncs and dot clock arrive asynchronously and are sampled.
//
// Our own choices: the address map and the strobed register port.
`include "rgi_regs.vh"
`timescale 1ns/10ps
`default_nettype none
// Block overview.
// The core takes pixels from an external video source over the pixel pins,
// qualified by a dot clock and either an enable or a pair of sync signals.
// Every pin is sampled by two flip-flops in the system clock domain before
// any logic looks at it. The dot clock itself is treated as data, and its
// rising edge is found by comparing the second and third stages.
// Assembled pixels either go straight out on the bypass port or are stored
// in the display RAM at the position the column and page counters point to.
// The host can also write and read the RAM through the data register,
// using the same counters, so both paths share one addressing scheme.
// Limitation: the dot clock must stay well below half the system clock,
// or edges are lost in the synchroniser. The video model keeps each level
// for four system clocks, which leaves ample margin.
module rgi_core (
  input wire mclk_i,
  input wire resetn_i,
  input wire [3:0] addr_i,
  input wire [17:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [17:0] rdata_o,
  input wire [17:0] pixel_data_pins_i,
  input wire dotclk_i,
  input wire vsync_i,
  input wire hsync_i,
  input wire enable_i,
  input wire [16:0] scan_addr_i,
  output reg [17:0] scan_data_o,
  output reg [17:0] bypass_data_o,
  output reg bypass_valid_o,
  output reg panel_tick_o,
  output wire rgb_active_o,
  output wire scroll_allowed_o
);
  reg [8:0] ctrl_q;
  reg [2:0] orient_q;
  reg [8:0] col_start_q, col_end_q, page_start_q, page_end_q;
  reg [8:0] scroll_top_q, scroll_area_q, scroll_bot_q, scroll_start_q;
  reg [8:0] col_q, page_q;
  reg writing_q, reading_q, frame_done_q;
  reg [17:0] ram [0:`RGI_RAM_WORDS-1];
  reg [17:0] rd_word_q;
  // Two-stage synchronisers; logic reads the second stage, and a third control stage for edge detection.
  reg [17:0] pix_s1_q, pix_s2_q;
  reg [3:0] ctl_s1_q, ctl_s2_q, ctl_s3_q;
  reg [1:0] phase_q;
  reg [17:0] acc_q;
  wire narrow = ctrl_q[`RGI_CTRL_NARROW];
  wire mempath = ctrl_q[`RGI_CTRL_MEMPATH];
  wire [1:0] mode = ctrl_q[`RGI_CTRL_MODE_HI:`RGI_CTRL_MODE_LO];
  wire [2:0] fmt = ctrl_q[`RGI_CTRL_FMT_HI:`RGI_CTRL_FMT_LO];
  wire rgb_en = ctrl_q[`RGI_CTRL_RGB_EN];
  wire cont = ctrl_q[`RGI_CTRL_CONT];
  assign rgb_active_o = rgb_en & mode[1];
  assign scroll_allowed_o = ~rgb_active_o;
  wire dclk_rise = ctl_s2_q[0] & ~ctl_s3_q[0];
  wire vs_fall = ~ctl_s2_q[1] & ctl_s3_q[1];
  wire hs_s = ctl_s2_q[2];
  wire vs_s = ctl_s2_q[1];
  wire de_s = ctl_s2_q[3];
  // Enable mode gates data by enable; sync mode by both syncs being inactive (low-active).
  wire active_px = (mode == `RGI_MODE_DE) ? de_s : (hs_s & vs_s);
  wire sample = rgb_active_o & dclk_rise & active_px;
  reg [17:0] pix_d;
  reg pix_done;
  reg [1:0] phase_d;
  reg [17:0] acc_d;
  // Pixel assembly for each bus width and colour format.
  // On the wide bus a pixel completes on every qualified dot clock edge.
  // On the narrow bus three edges carry red, green and blue in turn, and
  // the accumulator shifts left by six bits on each one. A frame start
  // clears the phase, so a frame that ended on a partial pixel cannot
  // shift the colours of the next frame; the partial pixel is simply lost.
  // The 16-bit formats widen red and blue to six bits by repeating the
  // top bit, which keeps full white at full scale.
  // Trade-off: the assembly is combinational, so the RAM write happens in
  // the same cycle the last component is sampled, at the cost of a longer
  // path from the synchroniser through the multiplexers.
  always @* begin
    pix_d = 18'h00000;
    pix_done = 1'b0;
    phase_d = phase_q;
    acc_d = acc_q;
    if (sample) begin
      if (!narrow) begin
        pix_done = 1'b1;
        if (fmt == `RGI_FMT_16)
          pix_d = {pix_s2_q[17:13], pix_s2_q[17], pix_s2_q[11:6],
                   pix_s2_q[5:1], pix_s2_q[5]};
        else
          pix_d = pix_s2_q;
      end else begin
        // Narrow bus: one colour per dot clock, three per pixel.
        acc_d = {acc_q[11:0], pix_s2_q[5:0]};
        if (phase_q == 2'h2) begin
          phase_d = 2'h0;
          pix_done = 1'b1;
          if (fmt == `RGI_FMT_16)
            pix_d = {acc_q[11:7], acc_q[11], acc_q[5:0], pix_s2_q[5:1], pix_s2_q[5]};
          else
            pix_d = {acc_q[11:0], pix_s2_q[5:0]};
        end else begin
          phase_d = phase_q + 2'h1;
        end
      end
    end
    if (vs_fall)
      phase_d = 2'h0;
  end
  // Logical to physical pointer mapping.
  // The exchange bit swaps which counter drives the physical column and
  // which drives the physical page. The mirror bits then reflect the
  // result about the last column or the last page.
  // The host must keep the window inside the physical limits for the
  // chosen orientation; a column value above the last column with the
  // mirror bit set would wrap and land outside the visible area.
  // The pixel word itself is never reordered by orientation.
  wire [8:0] lc = orient_q[`RGI_ORIENT_EXCH] ? page_q : col_q;
  wire [8:0] lp = orient_q[`RGI_ORIENT_EXCH] ? col_q : page_q;
  wire [8:0] phys_col = orient_q[`RGI_ORIENT_CMIR] ? (`RGI_COL_LAST - lc) : lc;
  wire [8:0] phys_page = orient_q[`RGI_ORIENT_PMIR] ? (`RGI_PAGE_LAST - lp) : lp;
  wire [16:0] phys_addr = phys_page[8:0] * 17'd240 + {8'h00, phys_col};
  wire cmd_wr = wr_i & (addr_i == `RGI_REG_CMD);
  wire data_wr = wr_i & (addr_i == `RGI_REG_RDDATA) & writing_q;
  wire data_rd = rd_i & (addr_i == `RGI_REG_RDDATA) & reading_q;
  wire ram_we = (pix_done & mempath & writing_q) | data_wr;
  wire step = ram_we | data_rd;
  wire [17:0] ram_wd = data_wr ? wdata_i : pix_d;
  wire col_wrap = (col_q >= col_end_q);
  wire page_wrap = (page_q >= page_end_q);
  // Register file, command decode and counters.
  // Reset values give the full screen as the window and a scroll area that
  // covers every line, so a display used without setup behaves sensibly.
  // The synchroniser stages are reset to zero; the syncs are active low,
  // so the first edges after reset see them rise, never fall, and no false
  // frame start is reported.
  // A command write takes priority over a pixel step in the same cycle,
  // so a restart always begins exactly at the start of the window.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `RGI_CTRL_RESET;
      orient_q <= 3'h0;
      col_start_q <= 9'h000;
      col_end_q <= `RGI_COL_LAST;
      page_start_q <= 9'h000;
      page_end_q <= `RGI_PAGE_LAST;
      scroll_top_q <= 9'h000;
      scroll_area_q <= 9'h140;
      scroll_bot_q <= 9'h000;
      scroll_start_q <= 9'h000;
      col_q <= 9'h000;
      page_q <= 9'h000;
      writing_q <= 1'b0;
      reading_q <= 1'b0;
      frame_done_q <= 1'b0;
      rdata_o <= 18'h00000;
      phase_q <= 2'h0;
      acc_q <= 18'h00000;
      pix_s1_q <= 18'h00000;
      pix_s2_q <= 18'h00000;
      ctl_s1_q <= 4'h0;
      ctl_s2_q <= 4'h0;
      ctl_s3_q <= 4'h0;
      bypass_data_o <= 18'h00000;
      bypass_valid_o <= 1'b0;
      panel_tick_o <= 1'b0;
    end else begin
      pix_s1_q <= pixel_data_pins_i;
      pix_s2_q <= pix_s1_q;
      ctl_s1_q <= {enable_i, hsync_i, vsync_i, dotclk_i};
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
      phase_q <= phase_d;
      acc_q <= acc_d;
      // Panel timing comes from the dot clock while RGB input is active.
      panel_tick_o <= rgb_active_o & dclk_rise;
      bypass_valid_o <= pix_done & ~mempath;
      if (pix_done & ~mempath)
        bypass_data_o <= pix_d;
      if (wr_i) begin
        case (addr_i)
          `RGI_REG_CTRL: ctrl_q <= wdata_i[8:0];
          `RGI_REG_ORIENT: orient_q <= wdata_i[2:0];
          `RGI_REG_COL_START: col_start_q <= wdata_i[8:0];
          `RGI_REG_COL_END: col_end_q <= wdata_i[8:0];
          `RGI_REG_PAGE_START: page_start_q <= wdata_i[8:0];
          `RGI_REG_PAGE_END: page_end_q <= wdata_i[8:0];
          // Scroll settings are frozen while RGB input is active.
          `RGI_REG_SCROLL_TOP: if (!rgb_active_o) scroll_top_q <= wdata_i[8:0];
          `RGI_REG_SCROLL_AREA: if (!rgb_active_o) scroll_area_q <= wdata_i[8:0];
          `RGI_REG_SCROLL_BOT: if (!rgb_active_o) scroll_bot_q <= wdata_i[8:0];
          `RGI_REG_SCROLL_START: if (!rgb_active_o) scroll_start_q <= wdata_i[8:0];
          default: ;
        endcase
      end
      // Memory write and read commands reload both counters and open the
      // data register in one direction only. Any other command code closes
      // the data register again, which is how a host ends a frame and later
      // restarts it with a fresh write command.
      // The counters step once per pixel written to or read from the RAM, whether
      // it came from the video pins or from the host, and wrap at the end of the window.
      // In continuous mode the write stays open after the last pixel, so
      // the next frame overwrites from the start without host action.
      if (cmd_wr && (wdata_i[7:0] == `RGI_CMD_WRITE || wdata_i[7:0] == `RGI_CMD_READ)) begin
        col_q <= col_start_q;
        page_q <= page_start_q;
        writing_q <= (wdata_i[7:0] == `RGI_CMD_WRITE);
        reading_q <= (wdata_i[7:0] == `RGI_CMD_READ);
        frame_done_q <= 1'b0;
      end else if (cmd_wr) begin
        writing_q <= 1'b0;
        reading_q <= 1'b0;
      end else if (step) begin
        if (!col_wrap) begin
          col_q <= col_q + 9'h001;
        end else begin
          col_q <= col_start_q;
          if (!page_wrap) begin
            page_q <= page_q + 9'h001;
          end else begin
            page_q <= page_start_q;
            frame_done_q <= 1'b1;
            // Without continuous mode the host must restart with a write command.
            if (!cont)
              writing_q <= 1'b0;
          end
        end
      end
      // A new frame on the video input restarts the window.
      if (vs_fall && rgb_active_o && mempath && !cmd_wr) begin
        col_q <= col_start_q;
        page_q <= page_start_q;
      end
      // Read data are registered and first stand in the cycle after the
      // strobe; they hold their value until the next strobe. Unmapped indices read zero
      // so that software probing the space sees no stale data.
      if (rd_i) begin
        case (addr_i)
          `RGI_REG_CTRL: rdata_o <= {9'h000, ctrl_q};
          `RGI_REG_ORIENT: rdata_o <= {15'h0000, orient_q};
          `RGI_REG_COL_START: rdata_o <= {9'h000, col_start_q};
          `RGI_REG_COL_END: rdata_o <= {9'h000, col_end_q};
          `RGI_REG_PAGE_START: rdata_o <= {9'h000, page_start_q};
          `RGI_REG_PAGE_END: rdata_o <= {9'h000, page_end_q};
          `RGI_REG_STATUS: rdata_o <= {6'h00, phase_q, frame_done_q, reading_q,
                                       writing_q, col_q[6:0]};
          `RGI_REG_SCROLL_TOP: rdata_o <= {9'h000, scroll_top_q};
          `RGI_REG_SCROLL_AREA: rdata_o <= {9'h000, scroll_area_q};
          `RGI_REG_SCROLL_BOT: rdata_o <= {9'h000, scroll_bot_q};
          `RGI_REG_SCROLL_START: rdata_o <= {9'h000, scroll_start_q};
          `RGI_REG_RDDATA: rdata_o <= reading_q ? rd_word_q : 18'h00000;
          default: rdata_o <= 18'h00000;
        endcase
      end
    end
  end
  // Dual-read RAM: the scan port is independent, so host traffic never disturbs it.
  // When the scan reads the word being written in the same cycle it sees
  // the old contents; the new word appears on the next scan, which shows
  // on the panel as a clean one-frame delay and never as a torn pixel.
  // The array is not reset; words never written read as unknown.
  always @(posedge mclk_i) begin
    if (ram_we)
      ram[phys_addr] <= ram_wd;
    scan_data_o <= ram[scan_addr_i];
  end
  // Prefetch of the word at the current read pointer.
  // Reading the array asynchronously lets the data register answer in the
  // cycle after the strobe, as the register port promises, while the
  // counter steps to the next word in the same cycle.
  always @* begin
    rd_word_q = ram[phys_addr];
  end
endmodule
`default_nettype wire

// ==== tb/rgi_core_checker.sv ====
// Checker for the pixel input core: register and video side ports.
// Assumes it is bound to every core instance.
`timescale 1ns/10ps
`default_nettype none
module rgi_core_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [17:0] rdata_o,
  input wire logic dotclk_i,
  input wire logic bypass_valid_o,
  input wire logic panel_tick_o,
  input wire logic rgb_active_o,
  input wire logic scroll_allowed_o
);
  // All checks share the one system clock and its reset.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_no_scroll; rgb_active_o |-> !scroll_allowed_o; endproperty
  a_no_scroll: assert property (p_no_scroll) else $error("scroll in video mode");
  property p_cfg_hold; !wr_i |=> $stable(rgb_active_o) && $stable(scroll_allowed_o); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("mode moved without write");
  property p_tick_mode; panel_tick_o |-> rgb_active_o; endproperty
  a_tick_mode: assert property (p_tick_mode) else $error("tick outside video mode");
  property p_tick_follow; rgb_active_o && $rose(dotclk_i) |-> ##[1:6] panel_tick_o; endproperty
  a_tick_follow: assert property (p_tick_follow) else $error("no tick after dot");
  property p_tick_pulse; panel_tick_o |=> !panel_tick_o; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_byp_mode; bypass_valid_o |-> rgb_active_o; endproperty
  a_byp_mode: assert property (p_byp_mode) else $error("bypass outside video");
  property p_rd_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; rd_i && addr_i > 4'hC |=> rdata_o == 18'h00000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind rgi_core rgi_core_checker u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .dotclk_i(dotclk_i),
  .bypass_valid_o(bypass_valid_o), .panel_tick_o(panel_tick_o), .rgb_active_o(rgb_active_o),
  .scroll_allowed_o(scroll_allowed_o));
`default_nettype wire

// ==== tb/rgi_video_src.sv ====
// Video source model: dot clock, syncs, enable and pixel pins.
// Assumes beat() and idle() are called just after a rising mclk edge.
`timescale 1ns/10ps
`default_nettype none
module rgi_video_src (
  input wire logic mclk_i,
  output logic [17:0] pins_o,
  output logic dotclk_o,
  output logic vsync_n_o,
  output logic hsync_n_o,
  output logic enable_o
);
  // Syncs rest inactive high; the dot clock stands still between beats.
  initial begin
    pins_o = 18'h15555;
    dotclk_o = 1'b0;
    vsync_n_o = 1'b1;
    hsync_n_o = 1'b1;
    enable_o = 1'b0;
  end
  // Data leads the dot rise by four cycles so both clear the synchroniser.
  task automatic beat(input logic [17:0] d);
    pins_o <= d;
    enable_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    dotclk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    dotclk_o <= 1'b0;
  endtask
  // Frame gap: sync width and porch both exceed the minimum counts.
  task automatic vframe;
    hsync_n_o <= 1'b1;
    vsync_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    vsync_n_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask
  // Released pins show the inverse so stale data cannot pass as valid.
  task automatic idle;
    pins_o <= ~pins_o;
    enable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/rgb_input_and_gram_addressing_test.sv ====
// Self-checking bench for the pixel input and display RAM addressing core.
// Assumes the core answers reads one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "rgi_regs.vh"
module rgb_input_and_gram_addressing_test;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [17:0] wdata = 18'h00000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [16:0] scan_addr = 17'h00000;
  wire [17:0] rdata, pins, scan_data, byp_data;
  wire dotclk, vsync_n, hsync_n, enable, byp_v, tick, act, scr;
  int errors = 0;
  int comparisons = 0;
  // 20 MHz system clock.
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  rgi_core dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pixel_data_pins_i(pins), .dotclk_i(dotclk),
    .vsync_i(vsync_n), .hsync_i(hsync_n), .enable_i(enable), .scan_addr_i(scan_addr),
    .scan_data_o(scan_data), .bypass_data_o(byp_data), .bypass_valid_o(byp_v),
    .panel_tick_o(tick), .rgb_active_o(act), .scroll_allowed_o(scr));
  rgi_video_src src (.mclk_i(mclk_i), .pins_o(pins), .dotclk_o(dotclk),
    .vsync_n_o(vsync_n), .hsync_n_o(hsync_n), .enable_o(enable));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A gap cycle after each strobe keeps every signal to one update per step.
  task automatic wreg(input logic [3:0] a, input logic [17:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [17:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(posedge mclk_i);
    chk("rdata", exp, rdata);
  endtask
  task automatic scan(input logic [16:0] a, input logic [17:0] exp);
    scan_addr <= a;
    repeat (2) @(posedge mclk_i);
    chk("scan", exp, scan_data);
  endtask
  task automatic test_done;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Second pixel of a burst lands where the default and each single orientation bit send it.
  task automatic s_orient;
    logic [2:0] o [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [16:0] a [4] = '{17'h00001, 17'h000F0, 17'h000EE, 17'h12B11};
    for (int i = 0; i < 4; i++) begin
      wreg(`RGI_REG_ORIENT, {15'h0000, o[i]});
      wreg(`RGI_REG_CMD, {10'h000, `RGI_CMD_WRITE});
      wreg(`RGI_REG_RDDATA, 18'h3F000);
      wreg(`RGI_REG_RDDATA, {15'h7E00, o[i]});
      scan(a[i], {15'h7E00, o[i]});
    end
    scan(17'h12B10, 18'h3F000);
    rreg(`RGI_REG_STATUS, 18'h00082);
    wreg(`RGI_REG_CMD, {10'h000, `RGI_CMD_STOP});
    wreg(`RGI_REG_RDDATA, 18'h00ABC);
    rreg(`RGI_REG_STATUS, 18'h00002);
    wreg(`RGI_REG_SCROLL_TOP, 18'h00002);
    wreg(`RGI_REG_SCROLL_AREA, 18'h0013C);
    wreg(`RGI_REG_SCROLL_BOT, 18'h00002);
    rreg(`RGI_REG_SCROLL_AREA, 18'h0013C);
    rreg(4'hF, 18'h00000);
  endtask
  // One pixel per mode and format through the path without display RAM.
  task automatic s_video;
    logic [8:0] c [3] = '{9'h0E8, 9'h0EC, 9'h0D8};
    logic [17:0] p [3] = '{18'h2D2B4, 18'h1A5C3, 18'h21043};
    logic [17:0] e [3] = '{18'h2D2B4, 18'h1A5C3, 18'h21042};
    logic [17:0] got;
    for (int i = 0; i < 3; i++) begin
      got = 18'h3FFFF;
      wreg(`RGI_REG_CTRL, {9'h000, c[i]});
      chk("mode", 18'h00002, {16'h0000, act, scr});
      fork
        src.beat(p[i]);
        for (int k = 0; k < 20; k++) begin
          @(posedge mclk_i);
          if (byp_v === 1'b1) got = byp_data;
        end
      join
      src.idle();
      chk("bypass", e[i], got);
      if (got === 18'h3FFFF) test_done();
    end
    wreg(`RGI_REG_SCROLL_AREA, 18'h00140);
    rreg(`RGI_REG_SCROLL_AREA, 18'h0013C);
  endtask
  // Three narrow beats stored as one pixel through display RAM.
  task automatic s_narrow;
    wreg(`RGI_REG_ORIENT, 18'h00000);
    wreg(`RGI_REG_CTRL, 18'h000EB);
    wreg(`RGI_REG_CMD, {10'h000, `RGI_CMD_WRITE});
    src.beat(18'h3FFD5);
    src.beat(18'h3FFEA);
    src.beat(18'h3FFF3);
    src.idle();
    repeat (6) @(posedge mclk_i);
    scan(17'h00000, 18'h15AB3);
    src.beat(18'h3FFFF);
    src.beat(18'h3FFFF);
    src.vframe();
    src.beat(18'h3FF0C);
    src.beat(18'h3FFE1);
    src.beat(18'h3FFFE);
    src.idle();
    repeat (6) @(posedge mclk_i);
    scan(17'h00000, 18'h0C87E);
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    s_orient();
    s_video();
    s_narrow();
    test_done();
  end
endmodule
`default_nettype wire
